// file: src/asr_rx.sv
/*
  Asynchronous serial receiver with an Avalon-MM register slave.
  Assumes RX_PIN_IN is already synchronous to SYS_CLK_IN; the baud divider is a parameter.
*/
`timescale 1ns/100ps
module asr_rx
  import asr_pkg::*;
#(
  parameter int unsigned CLK_PER_TICK = asr_pkg::BAUD_DIV
) (
  // Clock and reset
  input  wire logic                      SYS_CLK_IN,
  input  wire logic                      RST_N_IN,
  // Serial line
  input  wire logic                      RX_PIN_IN,
  // Avalon-MM slave
  input  wire logic [asr_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic                      AVS_READ_IN,
  input  wire logic                      AVS_WRITE_IN,
  input  wire logic [asr_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
  output logic      [asr_pkg::DATA_W-1:0] AVS_READDATA_OUT,
  output logic                           AVS_WAITREQUEST_OUT,
  // Interrupt
  output logic                           IRQ_OUT
);
  import asr_pkg::*;

  typedef enum logic [2:0] {
    ASR_IDLE  = 3'b000,
    ASR_START = 3'b001,
    ASR_DATA  = 3'b011,
    ASR_STOP  = 3'b010
  } asr_state_t;

  localparam int unsigned TW = $clog2(CLK_PER_TICK);

  asr_state_t         state_ff;
  logic [TW-1:0]      tdiv_ff;
  logic               tick;
  logic [3:0]         sub_ff;
  logic [3:0]         bitn_ff;
  logic [2:0]         smp_ff;
  logic               rx_d_ff;
  logic [CHAR_W-1:0]  receive_shift_register_ff;
  logic [CTL_W-1:0]   ctrl_ff;
  logic [ST_W-1:0]    mask_ff;
  logic               oerr_ff;
  logic               ferr_ff;
  logic               ack_ff;
  logic               rx_en;
  logic               majority;
  logic               done;
  logic               push;
  logic               pop;
  logic               fifo_empty;
  logic               fifo_full;
  logic [ST_W-1:0]    status;
  asr_char_t          push_char;
  asr_char_t          head_char;

  assign rx_en    = ctrl_ff[CTL_CONT_RX] && !ctrl_ff[CTL_SYNC] && ctrl_ff[CTL_PORT_EN];
  assign majority = (smp_ff[0] & smp_ff[1]) | (smp_ff[1] & smp_ff[2]) | (smp_ff[0] & smp_ff[2]);

  // Baud tick generator at sixteen ticks per bit
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || !rx_en) begin
      tdiv_ff <= '0;
    end else if (tdiv_ff == TW'(CLK_PER_TICK-1)) begin
      tdiv_ff <= '0;
    end else begin
      tdiv_ff <= tdiv_ff + TW'(1);
    end
  end
  assign tick = rx_en && (tdiv_ff == TW'(CLK_PER_TICK-1));

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      rx_d_ff <= 1'b1;
    end else begin
      rx_d_ff <= RX_PIN_IN;
    end
  end

  // Three samples around mid-bit feed the majority vote
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      smp_ff <= 3'h7;
    end else if (tick) begin
      smp_ff <= {smp_ff[1:0], RX_PIN_IN};
    end
  end

  assign done = tick && (state_ff == ASR_STOP) && (sub_ff == 4'(OVERSAMPLE-1));

  // Receive state machine
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || !rx_en) begin
      state_ff <= ASR_IDLE;
      sub_ff   <= '0;
      bitn_ff  <= '0;
    end else begin
      unique case (state_ff)
        ASR_IDLE: begin
          // Overrun blocks new characters until software clears it
          if (rx_d_ff && !RX_PIN_IN && !oerr_ff) begin
            state_ff <= ASR_START;
            sub_ff   <= '0;
          end
        end
        ASR_START: begin
          if (tick) begin
            sub_ff <= sub_ff + 4'h1;
            if (sub_ff == 4'(HALF_BIT-1)) begin
              sub_ff   <= '0;
              bitn_ff  <= '0;
              state_ff <= majority ? ASR_IDLE : ASR_DATA;
            end
          end
        end
        ASR_DATA: begin
          if (tick) begin
            sub_ff <= sub_ff + 4'h1;
            if (sub_ff == 4'(OVERSAMPLE-1)) begin
              sub_ff  <= '0;
              bitn_ff <= bitn_ff + 4'h1;
              if (bitn_ff == (ctrl_ff[CTL_NINE] ? 4'(CHAR_W-1) : 4'(CHAR_W-2))) begin
                state_ff <= ASR_STOP;
              end
            end
          end
        end
        ASR_STOP: begin
          if (tick) begin
            sub_ff <= sub_ff + 4'h1;
            if (done) begin
              state_ff <= ASR_IDLE;
            end
          end
        end
        default: state_ff <= ASR_IDLE;
      endcase
    end
  end

  // Receive shift register fills LSB first at the bit rate
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      receive_shift_register_ff <= '0;
    end else if (tick && state_ff == ASR_DATA && sub_ff == 4'(OVERSAMPLE-1)) begin
      receive_shift_register_ff <= {majority, receive_shift_register_ff[CHAR_W-1:1]};
    end
  end

  always_comb begin
    push_char.ferr = !majority;
    if (ctrl_ff[CTL_NINE]) begin
      push_char.data = receive_shift_register_ff;
    end else begin
      push_char.data = {1'b0, receive_shift_register_ff[CHAR_W-1:1]};
    end
  end

  assign push = done && !fifo_full;

  asr_fifo #(
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in    (SYS_CLK_IN),
    .rst_n_in  (RST_N_IN),
    .push_in   (push),
    .wdata_in  (push_char),
    .pop_in    (pop),
    .rdata_out (head_char),
    .empty_out (fifo_empty),
    .full_out  (fifo_full)
  );

  // Overrun: character completes with FIFO full; set wins over clear
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      oerr_ff <= 1'b0;
    end else if (done && fifo_full) begin
      oerr_ff <= 1'b1;
    end else if (ack_ff && AVS_WRITE_IN && AVS_ADDRESS_IN == OFS_STATUS && AVS_WRITEDATA_IN[ST_OERR]) begin
      oerr_ff <= 1'b0;
    end
  end

  // Framing error sticky; also carried per character in the data register
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ferr_ff <= 1'b0;
    end else if (push && push_char.ferr) begin
      ferr_ff <= 1'b1;
    end else if (ack_ff && AVS_WRITE_IN && AVS_ADDRESS_IN == OFS_STATUS && AVS_WRITEDATA_IN[ST_FERR]) begin
      ferr_ff <= 1'b0;
    end
  end

  // Receive flag is a level that tracks unread characters
  assign status = {ferr_ff, oerr_ff, !fifo_empty};

  // Avalon slave: one wait state, answer on the second cycle of a request
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) && !ack_ff);
    end
  end

  // Pop at the edge that captures the head, so a character landing in the wait state is not lost
  assign pop = AVS_READ_IN && !ack_ff && AVS_ADDRESS_IN == OFS_DATA;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_ff <= CTL_RST;
      mask_ff <= ST_RST;
    end else if (ack_ff && AVS_WRITE_IN) begin
      if (AVS_ADDRESS_IN == OFS_CTRL) begin
        ctrl_ff <= AVS_WRITEDATA_IN[CTL_W-1:0];
      end
      if (AVS_ADDRESS_IN == OFS_MASK) begin
        mask_ff <= AVS_WRITEDATA_IN[ST_W-1:0];
      end
    end
  end

  // Read data registered while waitrequest is high, stands at the accept edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      AVS_READDATA_OUT <= '0;
    end else if (AVS_READ_IN && !ack_ff) begin
      unique case (AVS_ADDRESS_IN)
        OFS_CTRL:   AVS_READDATA_OUT <= DATA_W'(ctrl_ff);
        OFS_DATA:   AVS_READDATA_OUT <= fifo_empty ? '0 : DATA_W'({head_char.ferr, head_char.data});
        OFS_STATUS: AVS_READDATA_OUT <= DATA_W'(status);
        OFS_MASK:   AVS_READDATA_OUT <= DATA_W'(mask_ff);
        default:    AVS_READDATA_OUT <= '0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(status & mask_ff);
    end
  end

  // Checks
  property p_en_gate;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !rx_en |=> state_ff == ASR_IDLE;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("receiver active while disabled");

  property p_start;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (state_ff == ASR_IDLE && rx_en && rx_d_ff && !RX_PIN_IN && !oerr_ff) |=> state_ff == ASR_START;
  endproperty
  a_start: assert property (p_start) else $error("falling edge did not start reception");

  property p_false_start;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (state_ff == ASR_START && tick && sub_ff == 4'(HALF_BIT-1) && majority) |=>
        state_ff == ASR_IDLE && !$rose(oerr_ff) && !$rose(ferr_ff);
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start not aborted");

  property p_half;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (state_ff == ASR_START && $changed(state_ff)) |-> sub_ff == 4'h0;
  endproperty
  a_half: assert property (p_half) else $error("start count not reset");

  property p_push;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (done && !fifo_full) |=> !fifo_empty && status[ST_RXIF];
  endproperty
  a_push: assert property (p_push) else $error("character not stored");

  property p_ovr;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (done && fifo_full) |-> !push ##1 oerr_ff;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_ovr_block;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (oerr_ff && state_ff == ASR_IDLE) |=> state_ff == ASR_IDLE;
  endproperty
  a_ovr_block: assert property (p_ovr_block) else $error("reception during overrun");

  property p_flag;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      pop ##1 (fifo_empty && !(|(status[ST_W-1:1] & mask_ff[ST_W-1:1]))) |-> !status[ST_RXIF] ##1 !IRQ_OUT;
  endproperty
  a_flag: assert property (p_flag) else $error("receive flag stuck");

  property p_stop;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (push && !majority) |=> ferr_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("framing error lost");
endmodule

// file: src/asr_pkg.sv
/*
  Shared constants, register map and carrier types of the asynchronous serial receiver.
  Assumes a single 40 MHz system clock; all users import this package whole.
*/
package asr_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 4'hC;

  // Control register fields
  localparam int unsigned CTL_CONT_RX = 0;
  localparam int unsigned CTL_SYNC    = 1;
  localparam int unsigned CTL_PORT_EN = 2;
  localparam int unsigned CTL_NINE = 3;
  localparam int unsigned CTL_W    = 4;
  localparam logic [CTL_W-1:0] CTL_RST = 4'h0;

  // Data register fields: bit 9 carries the framing error of that character
  localparam int unsigned DAT_FERR = 9;

  // Status register fields (sticky, write one to clear except the level bits)
  localparam int unsigned ST_RXIF = 0;
  localparam int unsigned ST_OERR = 1;
  localparam int unsigned ST_FERR = 2;
  localparam int unsigned ST_W    = 3;
  localparam logic [ST_W-1:0] ST_RST = 3'h0;

  // Timing: oversampling ratio and default clocks per baud tick; then FIFO depth and character width
  localparam int unsigned OVERSAMPLE  = 16;
  localparam int unsigned HALF_BIT    = OVERSAMPLE / 2;
  localparam int unsigned BAUD_DIV    = 22;
  localparam int unsigned FIFO_DEPTH  = 2;
  localparam int unsigned CHAR_W      = 9;

  // One finished character leaving the shifter
  typedef struct packed {
    logic              ferr;
    logic [CHAR_W-1:0] data;
  } asr_char_t;

endpackage

// file: src/asr_fifo.sv
/*
  Two-entry character FIFO between the shifter and the data register.
  Assumes the writer checks full itself; a push while full is dropped.
*/
`timescale 1ns/100ps
module asr_fifo
  import asr_pkg::*;
#(
  parameter int unsigned DEPTH = asr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Write side
  input  wire logic              push_in,
  input  asr_pkg::asr_char_t     wdata_in,
  // Read side
  input  wire logic              pop_in,
  output asr_pkg::asr_char_t     rdata_out,
  output logic                   empty_out,
  output logic                   full_out
);
  import asr_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  asr_char_t        mem_ff [DEPTH];
  logic [PW-1:0]    wp_ff;
  logic [PW-1:0]    rp_ff;
  logic [PW:0]      cnt_ff;
  logic             do_push;
  logic             do_pop;

  assign empty_out = (cnt_ff == '0);
  assign full_out  = (cnt_ff == (PW+1)'(DEPTH));
  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;
  assign rdata_out = mem_ff[rp_ff];

  function automatic logic [PW-1:0] nxt_ptr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_ff[wp_ff] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) begin
        wp_ff <= nxt_ptr(wp_ff);
      end
      if (do_pop) begin
        rp_ff <= nxt_ptr(rp_ff);
      end
      cnt_ff <= cnt_ff + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
endmodule

// file: testbench/asr_line_tx.sv
/*
  Remote serial transmitter model on the receive line: start, 8 or 9 data bits LSB first, stop.
  Assumes callers enter its tasks just after a rising clock edge; the line idles high.
*/
`timescale 1ns/100ps
module asr_line_tx #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input  wire logic clk_in,
  // Serial line
  output logic      line_out
);
  initial line_out = 1'b1;

  task automatic drive(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge clk_in);
  endtask

  // A stop of zero models a broken frame; the line is then returned to idle
  task automatic send(input logic [8:0] d, input int nbits, input logic stop);
    drive(1'b0, BIT_CLKS);
    for (int i = 0; i < nbits; i++) drive(d[i], BIT_CLKS);
    drive(stop, BIT_CLKS);
    if (!stop) drive(1'b1, BIT_CLKS);
  endtask

  // Low spike shorter than half a bit, so it must not pass as a start bit
  task automatic glitch(input int n);
    drive(1'b0, n);
    drive(1'b1, BIT_CLKS);
  endtask
endmodule

// file: testbench/asr_rx_bench.sv
/*
  Self-checking bench for the asynchronous serial receiver: Avalon-MM registers, line model, flags.
  Assumes CLK_PER_TICK of 2, so one bit lasts 32 system clocks.
*/
`timescale 1ns/100ps
module asr_rx_bench;
  import asr_pkg::*;
  localparam int unsigned TICKS    = 2;
  localparam int          BIT_CLKS = int'(TICKS * OVERSAMPLE);
  localparam logic [31:0] EN8      = 32'h5;

  logic        clk = 1'b0;
  logic        rst_n;
  logic        rx;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  logic        irq;
  int          failures    = 0;
  int          comparisons = 0;

  always #12.5 clk = ~clk;

  asr_rx #(.CLK_PER_TICK(TICKS)) dut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .RX_PIN_IN(rx),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .IRQ_OUT(irq)
  );

  asr_line_tx #(.BIT_CLKS(BIT_CLKS)) tx (.clk_in(clk), .line_out(rx));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low; one idle edge after release
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    q = rdata;
    if (n >= 64) chk("bus answer", 32'h1, 32'h0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask

  // Interrupt output lags the status by one cycle
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  task automatic t_regs;
    rd_chk("ctrl reset", OFS_CTRL, 32'h0);
    rd_chk("status reset", OFS_STATUS, 32'h0);
    rd_chk("mask reset", OFS_MASK, 32'h0);
    wr32(OFS_MASK, 32'h7);
    rd_chk("mask rw", OFS_MASK, 32'h7);
    wr32(4'h1, 32'hF);
    rd_chk("unmapped", 4'h1, 32'h0);
    rd_chk("data empty", OFS_DATA, 32'h0);
    irq_chk(1'b0);
    $display("test regs done");
  endtask

  task automatic t_enable;
    logic [31:0] bad [3] = '{32'h4, 32'h7, 32'h1};
    foreach (bad[i]) begin
      wr32(OFS_CTRL, bad[i]);
      tx.send(9'h05A, 8, 1'b1);
      rd_chk("disabled status", OFS_STATUS, 32'h0);
    end
    $display("test enable done");
  endtask

  task automatic t_basic;
    wr32(OFS_CTRL, EN8);
    tx.send(9'h0A5, 8, 1'b1);
    rd_chk("status after char", OFS_STATUS, 32'h1);
    irq_chk(1'b1);
    wr32(OFS_MASK, 32'h0);
    irq_chk(1'b0);
    wr32(OFS_MASK, 32'h7);
    rd_chk("data", OFS_DATA, 32'h0A5);
    rd_chk("status after read", OFS_STATUS, 32'h0);
    irq_chk(1'b0);
    $display("test basic done");
  endtask

  task automatic t_false_start;
    tx.glitch(BIT_CLKS / 2 - 6);
    rd_chk("no char no error", OFS_STATUS, 32'h0);
    tx.send(9'h03C, 8, 1'b1);
    rd_chk("char after spike", OFS_DATA, 32'h03C);
    $display("test false start done");
  endtask

  task automatic t_frame;
    tx.send(9'h055, 8, 1'b0);
    rd_chk("framing status", OFS_STATUS, 32'h5);
    rd_chk("framing data", OFS_DATA, 32'h255);
    wr32(OFS_STATUS, 32'h4);
    rd_chk("framing cleared", OFS_STATUS, 32'h0);
    tx.send(9'h055, 8, 1'b1);
    rd_chk("good frame data", OFS_DATA, 32'h055);
    $display("test frame done");
  endtask

  task automatic t_overrun;
    tx.send(9'h011, 8, 1'b1);
    tx.send(9'h022, 8, 1'b1);
    tx.send(9'h033, 8, 1'b1);
    rd_chk("overrun status", OFS_STATUS, 32'h3);
    rd_chk("oldest", OFS_DATA, 32'h011);
    rd_chk("second", OFS_DATA, 32'h022);
    rd_chk("third dropped", OFS_DATA, 32'h0);
    tx.send(9'h044, 8, 1'b1);
    rd_chk("stalled", OFS_STATUS, 32'h2);
    wr32(OFS_STATUS, 32'h2);
    tx.send(9'h066, 8, 1'b1);
    rd_chk("after clear", OFS_DATA, 32'h066);
    $display("test overrun done");
  endtask

  task automatic t_nine;
    wr32(OFS_CTRL, 32'hD);
    tx.send(9'h1A5, 9, 1'b1);
    rd_chk("nine bit", OFS_DATA, 32'h1A5);
    wr32(OFS_CTRL, EN8);
    tx.send(9'h1FF, 8, 1'b1);
    rd_chk("eight bit", OFS_DATA, 32'h0FF);
    $display("test nine done");
  endtask

  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is about 4700 clocks
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    rd    = 1'b0;
    wr    = 1'b0;
    addr  = 4'h0;
    wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enable();
    t_basic();
    t_false_start();
    t_frame();
    t_overrun();
    t_nine();
    test_done();
  end
endmodule
